// ===== hw/cdtor_defs.svh
// Register indices, field positions and reset values of the timing override bank.
// Contract
// R1 - Offset 0x1E is fifteenth fixed-colour byte, resets zero.
// R2 - Clock prepare: bit 7 selects override value.
// R3 - Clock zero: bit 7 selects override value.
// R4 - Clock trail: bit 7 selects override value.
// R5 - Clock post: bit 7 selects override value.
// R6 - Data prepare: bit 7 selects override value.
// R7 - Data zero: bit 7 selects override value.
// R8 - Data trail: bit 7 selects override value.
// R9 - Value field reads auto value unless overridden.
// R10 - All override bits reset to zero.
// R11 - Offset 0x1F reserved read/write byte, resets zero.
// R12 - Value writes ignored while override bit clear.
`ifndef CDTOR_DEFS_SVH
`define CDTOR_DEFS_SVH

// Printed offsets are register indices; the byte address is four times the index.
`define CDTOR_IDX_PATTERN_BYTE15 7'h1E
`define CDTOR_IDX_RESERVED_1F    7'h1F
`define CDTOR_IDX_CLK_PREPARE    7'h40
`define CDTOR_IDX_CLK_ZERO       7'h41
`define CDTOR_IDX_CLK_TRAIL      7'h42
`define CDTOR_IDX_CLK_POST       7'h43
`define CDTOR_IDX_DATA_PREPARE   7'h44
`define CDTOR_IDX_DATA_ZERO      7'h45
`define CDTOR_IDX_DATA_TRAIL     7'h46

`define CDTOR_NUM_TIMING         7
`define CDTOR_OVERRIDE_BIT       7
`define CDTOR_VALUE_MSB          6
`define CDTOR_VALUE_LSB          0

`define CDTOR_RST_PATTERN_BYTE15 8'h00
`define CDTOR_RST_RESERVED_1F    8'h00
`define CDTOR_RST_OVERRIDE       1'b0
`define CDTOR_RST_VALUE          7'h00

`endif

// ===== hw/cdtor_pkg.sv
// Types shared by the timing override register bank.
`default_nettype none

package cdtor_pkg;

  typedef logic [6:0] cdtor_val_type;

  // Last field sits in the low bits, so index 0 of a packed 7x7 array is clock prepare.
  typedef struct packed {
    cdtor_val_type data_trail;
    cdtor_val_type data_zero;
    cdtor_val_type data_prepare;
    cdtor_val_type clk_post;
    cdtor_val_type clk_trail;
    cdtor_val_type clk_zero;
    cdtor_val_type clk_prepare;
  } cdtor_timing_type;

  typedef logic [6:0][6:0] cdtor_timing_arr_type;

  typedef struct packed {
    logic       hit;
    logic [2:0] sel;
  } cdtor_tdec_type;

endpackage : cdtor_pkg

`default_nettype wire

// ===== hw/cdtor_regs.sv
// Wishbone register bank for the pattern byte and the D-PHY timing overrides.
`include "cdtor_defs.svh"
`timescale 1ns/10ps
`default_nettype none

module cdtor_regs
  import cdtor_pkg::*;
#(
  parameter int ADDR_W = 9
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             ce_i,
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [ADDR_W-1:0] wb_adr_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  input  wire cdtor_timing_type auto_timing_i,
  output cdtor_timing_type      timing_o,
  output logic      [6:0]       override_en_o,
  output logic      [7:0]       pattern_fixed_byte_fifteen_o
);

  function automatic cdtor_tdec_type timing_decode(input logic [6:0] idx);
    cdtor_tdec_type d;
    logic [6:0]     off;
    off   = idx - `CDTOR_IDX_CLK_PREPARE;
    d.hit = (idx >= `CDTOR_IDX_CLK_PREPARE) && (idx <= `CDTOR_IDX_DATA_TRAIL);
    d.sel = off[2:0];
    return d;
  endfunction : timing_decode

  // Entering override captures the live auto value, so the timing does not jump.
  function automatic cdtor_val_type value_next(input logic          ov,
                                               input cdtor_val_type wr,
                                               input cdtor_val_type auto_v);
    return ov ? wr : auto_v;
  endfunction : value_next

  logic [7:0]           pattern_reg;
  logic [7:0]           reserved_reg;
  logic [6:0]           ov_reg;
  cdtor_timing_arr_type val_reg;
  cdtor_timing_arr_type auto_arr;
  cdtor_timing_arr_type eff_next;
  logic                 clk_prepare_override_en_reg;
  logic                 clk_zero_override_en_reg;
  logic                 clk_trail_override_en_reg;
  logic                 clk_post_override_en_reg;
  logic                 data_prepare_override_en_reg;
  logic                 data_zero_override_en_reg;
  logic                 data_trail_override_en_reg;
  cdtor_val_type        clk_prepare_value_reg;
  cdtor_val_type        clk_zero_value_reg;
  cdtor_val_type        clk_trail_value_reg;
  cdtor_val_type        clk_post_value_reg;
  cdtor_val_type        data_prepare_value_reg;
  cdtor_val_type        data_zero_value_reg;
  cdtor_val_type        data_trail_value_reg;
  cdtor_val_type        clk_prepare_out_reg;
  cdtor_val_type        clk_zero_out_reg;
  cdtor_val_type        clk_trail_out_reg;
  cdtor_val_type        clk_post_out_reg;
  cdtor_val_type        data_prepare_out_reg;
  cdtor_val_type        data_zero_out_reg;
  cdtor_val_type        data_trail_out_reg;
  logic [6:0]           twr;
  cdtor_val_type        wr_value;
  logic                 ack_reg;
  logic [31:0]          dat_reg;
  logic [31:0]          dat_next;
  logic [6:0]           idx;
  cdtor_tdec_type       tdec;
  logic                 req;
  logic                 wr_lane0;

  assign auto_arr = auto_timing_i;
  assign idx      = 7'(wb_adr_i >> 2);
  assign tdec     = timing_decode(idx);
  // One access per cycle pair: a held request is not taken again while ack is high.
  assign req      = wb_cyc_i && wb_stb_i && !ack_reg;
  assign wr_lane0 = req && wb_we_i && wb_sel_i[0];
  assign wr_value = wb_dat_i[`CDTOR_VALUE_MSB:`CDTOR_VALUE_LSB];

  assign ov_reg = {
    data_trail_override_en_reg,
    data_zero_override_en_reg,
    data_prepare_override_en_reg,
    clk_post_override_en_reg,
    clk_trail_override_en_reg,
    clk_zero_override_en_reg,
    clk_prepare_override_en_reg
  };

  assign val_reg = {
    data_trail_value_reg,
    data_zero_value_reg,
    data_prepare_value_reg,
    clk_post_value_reg,
    clk_trail_value_reg,
    clk_zero_value_reg,
    clk_prepare_value_reg
  };

  // One-hot write strobe of the timing register that the current write addresses.
  always_comb begin
    twr = 7'h00;
    if (wr_lane0 && tdec.hit) begin
      twr[tdec.sel] = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else if (ce_i) begin
      ack_reg <= req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pattern_reg <= `CDTOR_RST_PATTERN_BYTE15; // [R1]
    end else if (ce_i && wr_lane0 && idx == `CDTOR_IDX_PATTERN_BYTE15) begin
      pattern_reg <= wb_dat_i[7:0]; // [R1]
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reserved_reg <= `CDTOR_RST_RESERVED_1F; // [R11]
    end else if (ce_i && wr_lane0 && idx == `CDTOR_IDX_RESERVED_1F) begin
      reserved_reg <= wb_dat_i[7:0]; // [R11]
    end
  end

  always_comb begin
    for (int i = 0; i < `CDTOR_NUM_TIMING; i++) begin
      // Clock lane: [R2] [R3] [R4] [R5]; data lane: [R6] [R7] [R8].
      eff_next[i] = ov_reg[i] ? val_reg[i] : auto_arr[i];
    end
  end

  // Clock-lane prepare.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clk_prepare_override_en_reg <= `CDTOR_RST_OVERRIDE; // [R10]
    end else if (ce_i && twr[0]) begin
      clk_prepare_override_en_reg <= wb_dat_i[`CDTOR_OVERRIDE_BIT]; // [R2]
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clk_prepare_value_reg <= `CDTOR_RST_VALUE;
    end else if (ce_i && twr[0]) begin
      clk_prepare_value_reg <=
          value_next(clk_prepare_override_en_reg, wr_value, auto_arr[0]); // [R12]
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clk_prepare_out_reg <= `CDTOR_RST_VALUE;
    end else if (ce_i) begin
      clk_prepare_out_reg <= eff_next[0]; // [R2]
    end
  end

  // Clock-lane zero.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clk_zero_override_en_reg <= `CDTOR_RST_OVERRIDE; // [R10]
    end else if (ce_i && twr[1]) begin
      clk_zero_override_en_reg <= wb_dat_i[`CDTOR_OVERRIDE_BIT]; // [R3]
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clk_zero_value_reg <= `CDTOR_RST_VALUE;
    end else if (ce_i && twr[1]) begin
      clk_zero_value_reg <=
          value_next(clk_zero_override_en_reg, wr_value, auto_arr[1]); // [R12]
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clk_zero_out_reg <= `CDTOR_RST_VALUE;
    end else if (ce_i) begin
      clk_zero_out_reg <= eff_next[1]; // [R3]
    end
  end

  // Clock-lane trail.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clk_trail_override_en_reg <= `CDTOR_RST_OVERRIDE; // [R10]
    end else if (ce_i && twr[2]) begin
      clk_trail_override_en_reg <= wb_dat_i[`CDTOR_OVERRIDE_BIT]; // [R4]
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clk_trail_value_reg <= `CDTOR_RST_VALUE;
    end else if (ce_i && twr[2]) begin
      clk_trail_value_reg <=
          value_next(clk_trail_override_en_reg, wr_value, auto_arr[2]); // [R12]
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clk_trail_out_reg <= `CDTOR_RST_VALUE;
    end else if (ce_i) begin
      clk_trail_out_reg <= eff_next[2]; // [R4]
    end
  end

  // Clock-lane post.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clk_post_override_en_reg <= `CDTOR_RST_OVERRIDE; // [R10]
    end else if (ce_i && twr[3]) begin
      clk_post_override_en_reg <= wb_dat_i[`CDTOR_OVERRIDE_BIT]; // [R5]
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clk_post_value_reg <= `CDTOR_RST_VALUE;
    end else if (ce_i && twr[3]) begin
      clk_post_value_reg <=
          value_next(clk_post_override_en_reg, wr_value, auto_arr[3]); // [R12]
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clk_post_out_reg <= `CDTOR_RST_VALUE;
    end else if (ce_i) begin
      clk_post_out_reg <= eff_next[3]; // [R5]
    end
  end

  // Data-lane prepare.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_prepare_override_en_reg <= `CDTOR_RST_OVERRIDE; // [R10]
    end else if (ce_i && twr[4]) begin
      data_prepare_override_en_reg <= wb_dat_i[`CDTOR_OVERRIDE_BIT]; // [R6]
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_prepare_value_reg <= `CDTOR_RST_VALUE;
    end else if (ce_i && twr[4]) begin
      data_prepare_value_reg <=
          value_next(data_prepare_override_en_reg, wr_value, auto_arr[4]); // [R12]
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_prepare_out_reg <= `CDTOR_RST_VALUE;
    end else if (ce_i) begin
      data_prepare_out_reg <= eff_next[4]; // [R6]
    end
  end

  // Data-lane zero.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_zero_override_en_reg <= `CDTOR_RST_OVERRIDE; // [R10]
    end else if (ce_i && twr[5]) begin
      data_zero_override_en_reg <= wb_dat_i[`CDTOR_OVERRIDE_BIT]; // [R7]
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_zero_value_reg <= `CDTOR_RST_VALUE;
    end else if (ce_i && twr[5]) begin
      data_zero_value_reg <=
          value_next(data_zero_override_en_reg, wr_value, auto_arr[5]); // [R12]
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_zero_out_reg <= `CDTOR_RST_VALUE;
    end else if (ce_i) begin
      data_zero_out_reg <= eff_next[5]; // [R7]
    end
  end

  // Data-lane trail.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_trail_override_en_reg <= `CDTOR_RST_OVERRIDE; // [R10]
    end else if (ce_i && twr[6]) begin
      data_trail_override_en_reg <= wb_dat_i[`CDTOR_OVERRIDE_BIT]; // [R8]
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_trail_value_reg <= `CDTOR_RST_VALUE;
    end else if (ce_i && twr[6]) begin
      data_trail_value_reg <=
          value_next(data_trail_override_en_reg, wr_value, auto_arr[6]); // [R12]
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_trail_out_reg <= `CDTOR_RST_VALUE;
    end else if (ce_i) begin
      data_trail_out_reg <= eff_next[6]; // [R8]
    end
  end

  // Unmapped indices read as zero and swallow writes, but still acknowledge.
  always_comb begin
    dat_next = 32'h0000_0000;
    if (tdec.hit) begin
      dat_next[7:0] = {ov_reg[tdec.sel], eff_next[tdec.sel]}; // [R9]
    end else if (idx == `CDTOR_IDX_PATTERN_BYTE15) begin
      dat_next[7:0] = pattern_reg;
    end else if (idx == `CDTOR_IDX_RESERVED_1F) begin
      dat_next[7:0] = reserved_reg;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_reg <= 32'h0000_0000;
    end else if (ce_i) begin
      dat_reg <= (req && !wb_we_i) ? dat_next : 32'h0000_0000;
    end
  end

  assign wb_ack_o                     = ack_reg;
  assign wb_dat_o                     = dat_reg;
  assign timing_o                     = {data_trail_out_reg,
                                         data_zero_out_reg,
                                         data_prepare_out_reg,
                                         clk_post_out_reg,
                                         clk_trail_out_reg,
                                         clk_zero_out_reg,
                                         clk_prepare_out_reg};
  assign override_en_o                = ov_reg;
  assign pattern_fixed_byte_fifteen_o = pattern_reg;

endmodule : cdtor_regs

`default_nettype wire

// ===== testbench/cdtor_regs_properties.sv
// Checker for the timing override bank ports.
`timescale 1ns/10ps
`default_nettype none
module cdtor_chk
  import cdtor_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire cdtor_timing_type auto_timing_i,
  input wire cdtor_timing_type timing_o,
  input wire logic [6:0] override_en_o
);
  // A low enable freezes the outputs, so it masks every auto-mode check.
  wire logic [6:0] o = override_en_o | {7{~ce_i}};
  wire cdtor_timing_arr_type t = timing_o;
  wire cdtor_timing_arr_type a = auto_timing_i;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_cp; !o[0] |=> t[0] == $past(a[0]); endproperty
  a_cp: assert property (p_cp) else $error("clk prep");
  property p_cz; !o[1] |=> t[1] == $past(a[1]); endproperty
  a_cz: assert property (p_cz) else $error("clk zero");
  property p_ct; !o[2] |=> t[2] == $past(a[2]); endproperty
  a_ct: assert property (p_ct) else $error("clk trail");
  property p_cs; !o[3] |=> t[3] == $past(a[3]); endproperty
  a_cs: assert property (p_cs) else $error("clk post");
  property p_dp; !o[4] |=> t[4] == $past(a[4]); endproperty
  a_dp: assert property (p_dp) else $error("data prep");
  property p_dz; !o[5] |=> t[5] == $past(a[5]); endproperty
  a_dz: assert property (p_dz) else $error("data zero");
  property p_dt; !o[6] |=> t[6] == $past(a[6]); endproperty
  a_dt: assert property (p_dt) else $error("data trail");
  property p_rs; $fell(rst_i) |-> override_en_o == 7'h00; endproperty
  a_rs: assert property (p_rs) else $error("override after reset");
endmodule : cdtor_chk
bind cdtor_regs cdtor_chk u_chk (.*);
`default_nettype wire

// ===== testbench/cdtor_regs_test.sv
// Bench for the timing override register bank.
`timescale 1ns/10ps
`default_nettype none
module cdtor_regs_test
  import cdtor_pkg::*;
;
  logic clk_i, rst_i, ce_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [3:0] wb_sel_i;
  logic [8:0] wb_adr_i, ad;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [7:0] pattern_fixed_byte_fifteen_o, q;
  logic [6:0] override_en_o;
  cdtor_timing_arr_type at, tv;
  int failures, n_tests;
  cdtor_regs i_dut (.auto_timing_i(at), .timing_o(tv), .*);
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  initial begin
    repeat (900) @(posedge clk_i);
    failures++;
    report_and_stop;
  end
  task automatic chk(input logic [7:0] s, e);
    n_tests++;
    if (s !== e) failures++;
    if (s !== e) $display("[ERR] %0t got %h exp %h", $time, s, e);
  endtask : chk
  // Ack is read at the edge itself, before the design's own updates land.
  task automatic acc(input logic w, input logic [8:0] d_a, input logic [7:0] d);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, d_a, 24'h0, d};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o[7:0];
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    @(posedge clk_i);
  endtask : acc
  task automatic report_and_stop;
    $display("%0d checks %0d fails", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : report_and_stop
  initial begin
    {rst_i, ce_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i} = 9'h181;
    {wb_adr_i, wb_dat_i} = 41'h0;
    for (int k = 0; k < 7; k++) at[k] = 7'h30 + 7'(k);
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk(pattern_fixed_byte_fifteen_o, 8'h00);
    acc(0, 9'h07C, 8'h00);
    chk(q, 8'h00);
    acc(1, 9'h078, 8'hA5);
    acc(1, 9'h07C, 8'h5A);
    acc(0, 9'h150, 8'h00);
    chk(q, 8'h00);
    chk(pattern_fixed_byte_fifteen_o, 8'hA5);
    acc(0, 9'h07C, 8'h00);
    chk(q, 8'h5A);
    $display("byte test done");
    for (int k = 0; k < 7; k++) begin
      ad = 9'h100 + 9'(4 * k);
      acc(1, ad, 8'h15);
      acc(0, ad, 8'h00);
      chk(q, {1'b0, at[k]});
      acc(1, ad, 8'h80);
      acc(1, ad, 8'hC0 + 8'(k));
      at[k] <= 7'h7F;
      acc(0, ad, 8'h00);
      chk(q, 8'hC0 + 8'(k));
      chk({override_en_o[k], tv[k]}, 8'hC0 + 8'(k));
    end
    $display("timing test done");
    acc(1, 9'h100, 8'h00);
    ce_i <= 1'b0;
    at[0] <= 7'h11;
    repeat (3) @(posedge clk_i);
    chk({override_en_o[0], tv[0]}, 8'h7F);
    ce_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk({override_en_o[0], tv[0]}, 8'h11);
    rst_i <= 1'b1;
    @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk({1'b0, override_en_o}, 8'h00);
    chk(pattern_fixed_byte_fifteen_o, 8'h00);
    $display("enable and reset test done");
    report_and_stop;
  end
endmodule : cdtor_regs_test
`default_nettype wire
